// ---- core/hms_pkg.sv ----
// Constants, encodings and state type for the halt mode sequencer
package hms_pkg;

    // Encoding of the halt mode requested by the CPU
    localparam logic [1:0] HMS_MODE_LIGHT    = 2'h1;
    localparam logic [1:0] HMS_MODE_DEEP     = 2'h2;
    localparam logic [1:0] HMS_MODE_STOP     = 2'h3;

    // Warm-up count select codes
    localparam logic [1:0] HMS_WUP_SEL_SHORT = 2'h1;
    localparam logic [1:0] HMS_WUP_SEL_MID   = 2'h2;
    localparam logic [1:0] HMS_WUP_SEL_LONG  = 2'h3;

    // Warm-up lengths in ticks of the selected clock
    localparam int         HMS_WARM_SHORT    = 2 ** 8;
    localparam int         HMS_WARM_MID      = 2 ** 14;
    localparam int         HMS_WARM_LONG     = 2 ** 16;
    localparam int         HMS_CNT_W         = 17;
    localparam logic [16:0] HMS_FLASH_CYCLES = 17'h01000;

    // Reset values of the gating outputs
    localparam logic       HMS_RST_RUN       = 1'b1;

    typedef enum logic [5:0] {
        HMS_RUN        = 6'h01,
        HMS_LIGHT      = 6'h02,
        HMS_DEEP       = 6'h04,
        HMS_STOP       = 6'h08,
        HMS_OSC_WARM   = 6'h10,
        HMS_FLASH_WARM = 6'h20
    } hms_state_t;

endpackage

// ---- core/hms_warmup_counter.sv ----
// Down counter that times the oscillator and flash warm-up phases
`timescale 1ns/1ps
module hms_warmup_counter #(
    parameter int CNT_W = 17
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] length,
    input  wire logic             tick,
    output logic                  done
);
    logic [CNT_W-1:0] count;
    logic             busy;

    // A start always reloads, so a phase change never inherits a stale count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (start) begin
                count <= length;
                busy  <= 1'b1;
            end else if (busy && tick) begin
                count <= count - CNT_W'(1);
                if (count == CNT_W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- core/hms_halt_sequencer.sv ----
// Halt mode sequencer: idle and stop states, wake-up and warm-up timing
// How it works
// - Light idle clocks only selected peripherals
// - CPU fetches nothing while in light idle
// - Deep idle keeps only oscillator and timer
// - Deep idle stops system clock distribution
// - Wake requests detected independent of system clock
// - Wake requests synchronized before operation resumes
// - Stop halts everything including the oscillator
// - Clock resumes after oscillator and flash warm-up
// - Select code sets oscillator warm-up count
// - Flash warm-up waits 4096 selected-clock ticks
// - Qualified enabled interrupt wakes, CPU services it
// - Stop release completes only after warm-up
`timescale 1ns/1ps
module hms_halt_sequencer
    import hms_pkg::*;
#(
    parameter int NUM_PERIPH        = 8,
    parameter int NUM_IRQ           = 8,
    parameter int WARM_SHORT_CYCLES = HMS_WARM_SHORT,
    parameter int WARM_MID_CYCLES   = HMS_WARM_MID,
    parameter int WARM_LONG_CYCLES  = HMS_WARM_LONG
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  clk_en,
    input  wire logic                  halt_req,
    input  wire logic [1:0]            halt_mode,
    input  wire logic [NUM_PERIPH-1:0] periph_keep,
    input  wire logic [1:0]            warmup_count_select,
    input  wire logic                  clock_source_slow,
    input  wire logic                  slow_clock,
    input  wire logic [NUM_IRQ-1:0]    irq_pin,
    input  wire logic                  nmi_pin,
    input  wire logic [NUM_IRQ-1:0]    irq_enable,
    input  wire logic [NUM_IRQ-1:0][2:0] irq_level,
    input  wire logic [2:0]            mask_level,
    output logic                       cpu_fetch_en,
    output logic                       sys_clk_en,
    output logic [NUM_PERIPH-1:0]      periph_clk_en,
    output logic                       osc_en,
    output logic                       clock_timer_en,
    output logic                       wake_service,
    output logic                       halted
);
    hms_state_t             state;
    hms_state_t             next_state;
    logic [NUM_IRQ-1:0]     irq_sync1;
    logic [NUM_IRQ-1:0]     irq_sync2;
    logic                   nmi_sync1;
    logic                   nmi_sync2;
    logic                   slow_sync1;
    logic                   slow_sync2;
    logic                   slow_sync3;
    logic [NUM_IRQ-1:0]     irq_ok;
    logic                   wake_any;
    logic                   slow_tick;
    logic                   warm_tick;
    logic                   warm_start;
    logic                   warm_done;
    logic [HMS_CNT_W-1:0]   osc_len;
    logic [HMS_CNT_W-1:0]   warm_len;
    logic [HMS_CNT_W-1:0]   phase_cycles;
    logic [HMS_CNT_W-1:0]   loaded_len;

    // Pins sampled on the free-running core clock, never the gated one
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_sync1  <= '0;
            irq_sync2  <= '0;
            nmi_sync1  <= 1'b0;
            nmi_sync2  <= 1'b0;
            slow_sync1 <= 1'b0;
            slow_sync2 <= 1'b0;
            slow_sync3 <= 1'b0;
        end else if (clk_en) begin
            irq_sync1  <= irq_pin;
            irq_sync2  <= irq_sync1;
            nmi_sync1  <= nmi_pin;
            nmi_sync2  <= nmi_sync1;
            slow_sync1 <= slow_clock;
            slow_sync2 <= slow_sync1;
            slow_sync3 <= slow_sync2;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
            // Level at or above the mask qualifies
            assign irq_ok[gi] = irq_sync2[gi] && irq_enable[gi] && (irq_level[gi] >= mask_level);
        end
    endgenerate

    assign wake_any  = (|irq_ok) || nmi_sync2;
    assign slow_tick = slow_sync2 && !slow_sync3;
    // Warm-up ticks come from the clock chosen by the source bit
    assign warm_tick = clock_source_slow ? slow_tick : 1'b1;

    always_comb begin
        unique case (warmup_count_select)
            HMS_WUP_SEL_MID:  osc_len = HMS_CNT_W'(WARM_MID_CYCLES);
            HMS_WUP_SEL_LONG: osc_len = HMS_CNT_W'(WARM_LONG_CYCLES);
            default:          osc_len = HMS_CNT_W'(WARM_SHORT_CYCLES);
        endcase
    end

    always_comb begin
        next_state = state;
        warm_start = 1'b0;
        warm_len   = osc_len;
        unique case (state)
            HMS_RUN: begin
                if (halt_req && halt_mode == HMS_MODE_LIGHT) begin
                    next_state = HMS_LIGHT;
                end else if (halt_req && halt_mode == HMS_MODE_DEEP) begin
                    next_state = HMS_DEEP;
                end else if (halt_req && halt_mode == HMS_MODE_STOP) begin
                    next_state = HMS_STOP;
                end
            end
            HMS_LIGHT, HMS_DEEP: begin
                if (wake_any) begin
                    next_state = HMS_RUN;
                end
            end
            HMS_STOP: begin
                if (wake_any) begin
                    next_state = HMS_OSC_WARM;
                    warm_start = 1'b1;
                end
            end
            HMS_OSC_WARM: begin
                if (warm_done) begin
                    next_state = HMS_FLASH_WARM;
                    warm_start = 1'b1;
                    warm_len   = HMS_FLASH_CYCLES;
                end
            end
            HMS_FLASH_WARM: begin
                if (warm_done) begin
                    next_state = HMS_RUN;
                end
            end
            default: next_state = HMS_RUN;
        endcase
    end

    hms_warmup_counter #(
        .CNT_W (HMS_CNT_W)
    ) u_warmup (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .start    (warm_start),
        .length   (warm_len),
        .tick     (warm_tick),
        .done     (warm_done)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= HMS_RUN;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Gates follow next_state so they change on the same edge as the state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_fetch_en   <= HMS_RST_RUN;
            sys_clk_en     <= HMS_RST_RUN;
            periph_clk_en  <= '1;
            osc_en         <= HMS_RST_RUN;
            clock_timer_en <= HMS_RST_RUN;
            wake_service   <= 1'b0;
            halted         <= 1'b0;
        end else if (clk_en) begin
            cpu_fetch_en   <= (next_state == HMS_RUN);
            sys_clk_en     <= (next_state == HMS_RUN) || (next_state == HMS_LIGHT);
            if (next_state == HMS_RUN) begin
                periph_clk_en <= '1;
            end else if (next_state == HMS_LIGHT) begin
                periph_clk_en <= periph_keep;
            end else begin
                periph_clk_en <= '0;
            end
            osc_en         <= (next_state != HMS_STOP);
            clock_timer_en <= (next_state != HMS_STOP);
            wake_service   <= (state != HMS_RUN) && (next_state == HMS_RUN);
            halted         <= (next_state != HMS_RUN);
        end
    end

    // Helper logic for the checks below
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_cycles <= '0;
            loaded_len   <= '0;
        end else if (clk_en) begin
            phase_cycles <= (next_state != state) ? '0 : phase_cycles + HMS_CNT_W'(1);
            if (warm_start) begin
                loaded_len <= warm_len;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_light_periph;
        ($past(clk_en) && state == HMS_LIGHT) |-> periph_clk_en == $past(periph_keep);
    endproperty
    a_light_periph: assert property (p_light_periph) else $error("light idle peripheral gating wrong");

    property p_no_fetch;
        state != HMS_RUN |-> !cpu_fetch_en;
    endproperty
    a_no_fetch: assert property (p_no_fetch) else $error("CPU fetch enabled while halted");

    property p_deep_keep;
        state == HMS_DEEP |-> osc_en && clock_timer_en && periph_clk_en == '0;
    endproperty
    a_deep_keep: assert property (p_deep_keep) else $error("deep idle keeps wrong functions");

    property p_deep_sysclk;
        state == HMS_DEEP |-> !sys_clk_en;
    endproperty
    a_deep_sysclk: assert property (p_deep_sysclk) else $error("system clock runs in deep idle");

    property p_sync_wake;
        (clk_en && (state == HMS_LIGHT || state == HMS_DEEP) && !nmi_sync2 && irq_sync2 == '0)
            |=> state != HMS_RUN;
    endproperty
    a_sync_wake: assert property (p_sync_wake) else $error("woke without synchronized request");

    property p_wake_resume;
        (clk_en && (state == HMS_LIGHT || state == HMS_DEEP) && wake_any)
            |=> state == HMS_RUN && cpu_fetch_en && wake_service;
    endproperty
    a_wake_resume: assert property (p_wake_resume) else $error("qualified interrupt did not wake");

    property p_stop_off;
        state == HMS_STOP |-> !osc_en && !clock_timer_en && !sys_clk_en;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("circuit running in stop");

    property p_warm_gated;
        (state == HMS_OSC_WARM || state == HMS_FLASH_WARM) |-> !sys_clk_en && !cpu_fetch_en;
    endproperty
    a_warm_gated: assert property (p_warm_gated) else $error("clock released during warm-up");

    property p_osc_len;
        (state == HMS_OSC_WARM && warm_done && !clock_source_slow) |-> phase_cycles == loaded_len;
    endproperty
    a_osc_len: assert property (p_osc_len) else $error("oscillator warm-up length wrong");

    property p_flash_len;
        (state == HMS_FLASH_WARM && warm_done && !clock_source_slow)
            |-> phase_cycles == HMS_FLASH_CYCLES;
    endproperty
    a_flash_len: assert property (p_flash_len) else $error("flash warm-up length wrong");

    property p_stop_restart;
        (clk_en && state == HMS_STOP && wake_any) |=> state == HMS_OSC_WARM && osc_en;
    endproperty
    a_stop_restart: assert property (p_stop_restart) else $error("warm-up did not start");

    property p_release;
        (clk_en && state == HMS_FLASH_WARM && warm_done) |=> sys_clk_en && wake_service;
    endproperty
    a_release: assert property (p_release) else $error("gate not released at terminal count");

    c_light_wake: cover property (state == HMS_LIGHT ##1 state == HMS_RUN);
    c_deep_wake:  cover property (state == HMS_DEEP ##1 state == HMS_RUN);
    c_stop_wake:  cover property (state == HMS_FLASH_WARM ##1 state == HMS_RUN);
    c_slow_warm:  cover property (state == HMS_OSC_WARM && clock_source_slow && warm_done);
endmodule

// ---- verification/hms_cpu_irq_model.sv ----
// Model of the interrupt sources and the slow oscillator, which runs while slow_run is high
`timescale 1ns/1ps
module hms_cpu_irq_model #(
    parameter int NUM_IRQ = 8
) (
    input  wire logic [NUM_IRQ-1:0] irq_req,
    input  wire logic               nmi_req,
    input  wire logic               slow_run,
    output logic      [NUM_IRQ-1:0] irq_pin,
    output logic                    nmi_pin,
    output logic                    slow_clock
);
    // Pins change with no regard to core_clk, so the sequencer must sync them
    assign irq_pin = irq_req;
    assign nmi_pin = nmi_req;
    initial slow_clock = 1'b0;
    // Odd half period keeps the slow ticks out of phase with core_clk
    always begin
        #73;
        if (slow_run) begin
            slow_clock = ~slow_clock;
        end
    end
endmodule

// ---- verification/halt_mode_sequencer_test.sv ----
// Self-checking testbench for the halt mode sequencer
`timescale 1ns/1ps
module halt_mode_sequencer_test;
    import hms_pkg::*;
    localparam int LT [4] = '{4, 4, 8, 16};
    logic            core_clk = 1'b0;
    logic            rst_b = 1'b0;
    logic            clk_en = 1'b1;
    logic            halt_req = 1'b0;
    logic [1:0]      halt_mode = 2'h0;
    logic [7:0]      periph_keep = 8'h00;
    logic [1:0]      warmup_count_select = 2'h1;
    logic            clock_source_slow = 1'b0;
    logic            slow_clock;
    logic [7:0]      irq_req = 8'h00;
    logic            nmi_req = 1'b0;
    logic            slow_run = 1'b0;
    logic [7:0]      irq_pin;
    logic            nmi_pin;
    logic [7:0]      irq_enable = 8'hFB;
    logic [7:0][2:0] irq_level = {{5{3'h4}}, 3'h7, 3'h1, 3'h4};
    logic [2:0]      mask_level = 3'h3;
    logic            cpu_fetch_en, sys_clk_en, osc_en, clock_timer_en, wake_service, halted;
    logic [7:0]      periph_clk_en;
    int              fail_count = 0;
    int              n_checks = 0;

    always #20 core_clk = ~core_clk;

    hms_cpu_irq_model #(.NUM_IRQ(8)) partner (.irq_req(irq_req), .nmi_req(nmi_req),
        .slow_run(slow_run), .irq_pin(irq_pin), .nmi_pin(nmi_pin), .slow_clock(slow_clock));

    hms_halt_sequencer #(.NUM_PERIPH(8), .NUM_IRQ(8), .WARM_SHORT_CYCLES(4),
        .WARM_MID_CYCLES(8), .WARM_LONG_CYCLES(16)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .clk_en(clk_en), .halt_req(halt_req), .halt_mode(halt_mode), .periph_keep(periph_keep),
        .warmup_count_select(warmup_count_select), .clock_source_slow(clock_source_slow),
        .slow_clock(slow_clock), .irq_pin(irq_pin), .nmi_pin(nmi_pin), .irq_enable(irq_enable),
        .irq_level(irq_level), .mask_level(mask_level), .cpu_fetch_en(cpu_fetch_en),
        .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
        .clock_timer_en(clock_timer_en), .wake_service(wake_service), .halted(halted));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic cyc;
        @(posedge core_clk);
        #1;
    endtask

    task automatic halt_enter(input logic [1:0] m);
        @(posedge core_clk);
        halt_req  <= 1'b1;
        halt_mode <= m;
        @(posedge core_clk);
        halt_req  <= 1'b0;
        #1;
    endtask

    // Bounded wait for the return to RUN, counting edges since the request
    task automatic run_wait(input int max, inout int cnt);
        while (halted !== 1'b0 && cnt < max) begin
            cyc();
            cnt++;
        end
        if (halted !== 1'b0) begin
            fail_count++;
            $display("[FAIL] %0t: no wake", $time);
        end
    endtask

    // Requests are levels; drain the syncs so a later halt is not woken at once
    task automatic quiet;
        @(posedge core_clk);
        irq_req <= 8'h00;
        nmi_req <= 1'b0;
        repeat (4) cyc();
    endtask

    task automatic t_light;
        int c;
        c = 0;
        @(posedge core_clk);
        periph_keep <= 8'hA5;
        halt_enter(2'h0);
        chk(halted, 1'b0);
        halt_enter(HMS_MODE_LIGHT);
        chk(halted, 1'b1);
        chk(cpu_fetch_en, 1'b0);
        chk(sys_clk_en, 1'b1);
        chk(periph_clk_en, 8'hA5);
        @(posedge core_clk);
        irq_req <= 8'h06;
        repeat (6) cyc();
        chk(halted, 1'b1);
        @(posedge core_clk);
        irq_req <= 8'h01;
        run_wait(20, c);
        chk(c, 3);
        chk(wake_service, 1'b1);
        chk(cpu_fetch_en, 1'b1);
        chk(periph_clk_en, 8'hFF);
        cyc();
        chk(wake_service, 1'b0);
        quiet();
        $display("test light idle done");
    endtask

    task automatic t_deep;
        int c;
        c = 0;
        halt_enter(HMS_MODE_DEEP);
        chk(sys_clk_en, 1'b0);
        chk(periph_clk_en, 8'h00);
        chk({osc_en, clock_timer_en}, 2'h3);
        @(posedge core_clk);
        nmi_req <= 1'b1;
        run_wait(20, c);
        chk(c, 3);
        chk(wake_service, 1'b1);
        quiet();
        $display("test deep idle done");
    endtask

    // Low enable must freeze the syncs, so a request raised then wakes only once the enable returns
    task automatic t_freeze;
        int c;
        c = 0;
        halt_enter(HMS_MODE_LIGHT);
        @(posedge core_clk);
        clk_en  <= 1'b0;
        irq_req <= 8'h01;
        repeat (5) cyc();
        chk({halted, cpu_fetch_en, periph_clk_en}, 10'h2A5);
        @(posedge core_clk);
        clk_en <= 1'b1;
        run_wait(20, c);
        chk(c, 3);
        chk(wake_service, 1'b1);
        quiet();
        $display("test clock enable freeze done");
    endtask

    // Raised mask refuses a level-4 request; a disabled level-7 one wakes one edge after its enable is set
    task automatic t_mask;
        int c;
        c = 0;
        @(posedge core_clk);
        mask_level <= 3'h5;
        halt_enter(HMS_MODE_DEEP);
        @(posedge core_clk);
        irq_req <= 8'h05;
        repeat (6) cyc();
        chk(halted, 1'b1);
        @(posedge core_clk);
        irq_enable <= 8'hFF;
        run_wait(20, c);
        chk(c, 1);
        chk(wake_service, 1'b1);
        @(posedge core_clk);
        mask_level <= 3'h3;
        irq_enable <= 8'hFB;
        quiet();
        $display("test mask and enable done");
    endtask

    task automatic t_stop(input logic [1:0] code, input logic slow);
        int c;
        c = 4;
        @(posedge core_clk);
        warmup_count_select <= code;
        clock_source_slow   <= slow;
        slow_run            <= slow;
        halt_enter(HMS_MODE_STOP);
        chk({osc_en, clock_timer_en, sys_clk_en}, 3'h0);
        @(posedge core_clk);
        irq_req <= 8'h80;
        repeat (4) cyc();
        chk({osc_en, clock_timer_en, sys_clk_en, halted}, 4'hD);
        run_wait(20000, c);
        if (slow) begin
            chk(c >= 14960 && c <= 14980, 1'b1);
        end else begin
            chk(c, 3 + LT[code] + 4098);
        end
        chk({sys_clk_en, wake_service}, 2'h3);
        quiet();
        slow_run <= 1'b0;
        $display("test stop code %0d slow %0d done", code, slow);
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        chk({cpu_fetch_en, sys_clk_en, osc_en, clock_timer_en, periph_clk_en}, 12'hFFF);
        rst_b <= 1'b1;
        cyc();
        chk({wake_service, halted}, 2'h0);
        $display("test reset done");
        t_light();
        t_deep();
        t_freeze();
        t_mask();
        for (int k = 1; k < 4; k++) begin
            t_stop(k[1:0], 1'b0);
        end
        t_stop(2'h0, 1'b1);
        report_and_stop();
    end
endmodule
